// ---- src/rtcsp_defs.svh ----
`ifndef RTCSP_DEFS_SVH
`define RTCSP_DEFS_SVH
`define RTCSP_SLAVE_ADDR     7'h68
`define RTCSP_MEM_DEPTH      64
`define RTCSP_CAL_BYTES      8
`define RTCSP_PTR_RESET      6'h00
`define RTCSP_SYNC_STAGES    2
`define RTCSP_FILT_LEN       3
`define RTCSP_BYTE_RESET     8'h00
`endif

// ---- src/rtcsp_pkg.sv ----
package rtcsp_pkg;
	typedef enum logic [2:0] {
		RTCSP_IDLE  = 3'b000,
		RTCSP_ADDR  = 3'b001,
		RTCSP_ACK   = 3'b010,
		RTCSP_RX    = 3'b011,
		RTCSP_TX    = 3'b100,
		RTCSP_MACK  = 3'b101,
		RTCSP_WAIT  = 3'b110
	} rtcsp_state_t;
endpackage

// ---- src/rtcsp_slave.sv ----
`timescale 1ns/1ps
`include "rtcsp_defs.svh"
// How it works
// - Slave only; never drives clock or conditions.
// - Answer only slave address 68h: byte D0h to write, D1h to read.
// - Sixty-four byte locations in fixed order.
// - Lowest eight bytes hold BCD calendar values.
// - Pointer advances after every stored write byte and every master-acknowledged read byte.
// - Power fail aborts transfer, clears pointer.
// - Ignore bus while power fail active.
// - Both lines high means bus idle.
// - Transmitter holds data while clock high.
// - Data change with clock high is control.
// - Data falling, clock high, is START.
// - Data rising, clock high, is STOP.
// - One clock per bit, change when low.
// - Unlimited bytes between START and STOP.
// - Eight-bit bytes plus ninth acknowledge clock.
// - First write byte loads pointer, rest stored.
// - Read pointer advances only on master acknowledge.
// - No master acknowledge releases data line.
// - Bare read starts at current pointer.
module rtcsp_slave
	import rtcsp_pkg::*;
#(
	parameter int MEM_DEPTH = `RTCSP_MEM_DEPTH
) (
	// Clock and reset.
	input  wire logic       sys_clk_in,
	input  wire logic       rstn_in,
	// Two-wire bus pins; the clock pin is input only.
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Supply monitor: high while supply is under power_fail_threshold.
	input  wire logic       power_fail_in,
	// Status.
	output logic            busy_out,
	output logic [5:0]      ptr_out
);
	if (MEM_DEPTH != `RTCSP_MEM_DEPTH) begin : g_depth_check
		$error("rtcsp_slave: the six-bit pointer serves only a depth of 64");
	end

	// Two sync stages, then a filter that changes only when all three samples agree.
	logic [1:0] scl_sync_r, sda_sync_r, scl_sync_nxt, sda_sync_nxt;
	logic [`RTCSP_FILT_LEN-1:0] scl_hist_r, sda_hist_r, scl_hist_nxt, sda_hist_nxt;
	logic scl_f_r, sda_f_r, scl_f_nxt, sda_f_nxt;
	logic scl_d_r, sda_d_r, scl_d_nxt, sda_d_nxt;

	always_comb begin
		scl_sync_nxt = {scl_sync_r[0], scl_in};
		sda_sync_nxt = {sda_sync_r[0], sda_in};
		scl_hist_nxt = {scl_hist_r[`RTCSP_FILT_LEN-2:0], scl_sync_r[1]};
		sda_hist_nxt = {sda_hist_r[`RTCSP_FILT_LEN-2:0], sda_sync_r[1]};
		scl_f_nxt = (&scl_hist_r) ? 1'b1 : ((|scl_hist_r) ? scl_f_r : 1'b0);
		sda_f_nxt = (&sda_hist_r) ? 1'b1 : ((|sda_hist_r) ? sda_f_r : 1'b0);
		scl_d_nxt = scl_f_r;
		sda_d_nxt = sda_f_r;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_sync_r <= 2'b11;
			sda_sync_r <= 2'b11;
			scl_hist_r <= '1;
			sda_hist_r <= '1;
			scl_f_r    <= 1'b1;
			sda_f_r    <= 1'b1;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end else begin
			scl_sync_r <= scl_sync_nxt;
			sda_sync_r <= sda_sync_nxt;
			scl_hist_r <= scl_hist_nxt;
			sda_hist_r <= sda_hist_nxt;
			scl_f_r    <= scl_f_nxt;
			sda_f_r    <= sda_f_nxt;
			scl_d_r    <= scl_d_nxt;
			sda_d_r    <= sda_d_nxt;
		end
	end

	wire scl_rise = scl_f_r & ~scl_d_r;
	wire scl_fall = ~scl_f_r & scl_d_r;
	wire start_c  = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
	wire stop_c   = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

	// Storage; the lowest eight bytes are the BCD calendar, held as written.
	logic [7:0] mem_r [MEM_DEPTH];
	logic [7:0] mem_nxt [MEM_DEPTH];

	rtcsp_state_t state_r, state_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [5:0] ptr_r, ptr_nxt;
	logic       rd_r, rd_nxt;
	logic       first_r, first_nxt;
	logic       sda_o_r, sda_o_nxt;
	logic       sda_oe_r, sda_oe_nxt;
	logic       busy_r, busy_nxt;

	function automatic logic [5:0] ptr_inc(input logic [5:0] p);
		ptr_inc = p + 6'h01;
	endfunction

	always_comb begin
		state_nxt = state_r;
		bit_nxt   = bit_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		rd_nxt    = rd_r;
		first_nxt = first_r;
		sda_o_nxt = sda_o_r;
		busy_nxt  = busy_r;
		mem_nxt   = mem_r;
		if (power_fail_in) begin
			// Ignoring the bus here guards the memory from a sagging master.
			state_nxt = RTCSP_IDLE;
			ptr_nxt   = `RTCSP_PTR_RESET;
			sda_o_nxt = 1'b1;
			busy_nxt  = 1'b0;
		end else if (start_c) begin
			state_nxt = RTCSP_ADDR;
			bit_nxt   = 4'h0;
			sda_o_nxt = 1'b1;
			busy_nxt  = 1'b1;
		end else if (stop_c) begin
			state_nxt = RTCSP_IDLE;
			sda_o_nxt = 1'b1;
			busy_nxt  = 1'b0;
		end else begin
			unique case (state_r)
				RTCSP_IDLE, RTCSP_WAIT: begin
					sda_o_nxt = 1'b1;
				end
				RTCSP_ADDR, RTCSP_RX: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_f_r};
						bit_nxt = bit_r + 4'h1;
					end else if (scl_fall && bit_r == 4'h8) begin
						if (state_r == RTCSP_ADDR) begin
							if (sh_r[7:1] == `RTCSP_SLAVE_ADDR) begin
								rd_nxt    = sh_r[0];
								first_nxt = ~sh_r[0];
								sda_o_nxt = 1'b0;
								state_nxt = RTCSP_ACK;
							end else begin
								state_nxt = RTCSP_WAIT;
							end
						end else begin
							if (first_r) begin
								ptr_nxt   = sh_r[5:0];
								first_nxt = 1'b0;
							end else begin
								mem_nxt[ptr_r] = sh_r;
								ptr_nxt = ptr_inc(ptr_r);
							end
							sda_o_nxt = 1'b0;
							state_nxt = RTCSP_ACK;
						end
					end
				end
				RTCSP_ACK: begin
					if (scl_fall) begin
						bit_nxt = 4'h0;
						if (rd_r) begin
							sh_nxt    = mem_r[ptr_r];
							sda_o_nxt = mem_r[ptr_r][7];
							state_nxt = RTCSP_TX;
						end else begin
							sda_o_nxt = 1'b1;
							state_nxt = RTCSP_RX;
						end
					end
				end
				RTCSP_TX: begin
					// Data only changes after a falling clock edge.
					if (scl_fall) begin
						bit_nxt = bit_r + 4'h1;
						sh_nxt  = {sh_r[6:0], 1'b0};
						sda_o_nxt = (bit_r == 4'h7) ? 1'b1 : sh_r[6];
						if (bit_r == 4'h7) begin
							state_nxt = RTCSP_MACK;
						end
					end
				end
				RTCSP_MACK: begin
					if (scl_rise) begin
						if (!sda_f_r) begin
							ptr_nxt   = ptr_inc(ptr_r);
							state_nxt = RTCSP_ACK;
						end else begin
							state_nxt = RTCSP_WAIT;
						end
					end
				end
				default: begin
					state_nxt = RTCSP_IDLE;
				end
			endcase
		end
		sda_oe_nxt = ~sda_o_nxt;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= RTCSP_IDLE;
			bit_r   <= 4'h0;
			sh_r    <= `RTCSP_BYTE_RESET;
			ptr_r   <= `RTCSP_PTR_RESET;
			rd_r    <= 1'b0;
			first_r <= 1'b0;
			sda_o_r <= 1'b1;
			sda_oe_r <= 1'b0;
			busy_r  <= 1'b0;
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_r[i] <= `RTCSP_BYTE_RESET;
			end
		end else begin
			state_r <= state_nxt;
			bit_r   <= bit_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			rd_r    <= rd_nxt;
			first_r <= first_nxt;
			sda_o_r <= sda_o_nxt;
			sda_oe_r <= sda_oe_nxt;
			busy_r  <= busy_nxt;
			mem_r   <= mem_nxt;
		end
	end

	// Open drain: only a low is ever driven, the clock pin never.
	assign sda_out    = 1'b0;
	// The enable has its own flop, so no inverter sits between flop and pin.
	assign sda_oe_out = sda_oe_r;
	assign busy_out   = busy_r;
	assign ptr_out    = ptr_r;

	property p_pf_clear;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		power_fail_in |=> (ptr_r == 6'h00) && !sda_oe_out && (state_r == RTCSP_IDLE);
	endproperty
	a_pf_clear: assert property (p_pf_clear) else $error("power fail did not abort");

	property p_pf_ignore;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		power_fail_in && $past(power_fail_in) |-> !busy_r;
	endproperty
	a_pf_ignore: assert property (p_pf_ignore) else $error("bus seen in power fail");

	property p_start;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		start_c && !power_fail_in |=> state_r == RTCSP_ADDR && bit_r == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		stop_c |=> state_r == RTCSP_IDLE && !busy_r;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_wrap;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r == RTCSP_MACK && scl_rise && !sda_f_r && !power_fail_in && !start_c
			&& !stop_c && ptr_r == 6'h3f |=> ptr_r == 6'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

	property p_nack;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r == RTCSP_MACK && scl_rise && sda_f_r && !power_fail_in && !start_c
			&& !stop_c |=> !sda_oe_out && $stable(ptr_r);
	endproperty
	a_nack: assert property (p_nack) else $error("nack not released");

	property p_scl_stable;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r == RTCSP_TX && scl_f_r && scl_d_r && !start_c && !stop_c
			&& !power_fail_in |=> $stable(sda_oe_out);
	endproperty
	a_scl_stable: assert property (p_scl_stable) else $error("data moved, clock high");

	property p_addr_ack;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r == RTCSP_ADDR && scl_fall && bit_r == 4'h8 && sh_r[7:1] != `RTCSP_SLAVE_ADDR
			&& !power_fail_in && !start_c && !stop_c |=> state_r == RTCSP_WAIT ##1 !sda_oe_out;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("foreign address acked");
endmodule

// ---- dv/rtcsp_master_model.sv ----
`timescale 1ns/1ps
// Behavioural bus master. A released data line reads high through the pull-up.
module rtcsp_master_model #(
	parameter int PH = 12
) (
	// Clock.
	input  wire logic       clk_in,
	// Resolved bus data and driven bus lines.
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            sda_out,
	// Each finished byte with its ninth bit.
	output logic            got_v_out,
	output logic [8:0]      got_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		got_v_out = 1'b0;
		got_out = 9'h000;
	end
	task automatic wt();
		repeat (PH) @(posedge clk_in);
	endtask
	// Every phase lasts PH clocks, well above the slave's input filter delay.
	task automatic start_c();
		sda_out <= 1'b1;
		wt();
		scl_out <= 1'b1;
		wt();
		sda_out <= 1'b0;
		wt();
		scl_out <= 1'b0;
		wt();
	endtask
	task automatic stop_c();
		sda_out <= 1'b0;
		wt();
		scl_out <= 1'b1;
		wt();
		sda_out <= 1'b1;
		wt();
	endtask
	// Data moves only while the clock is low, one pulse per bit.
	task automatic bit_io(input logic b, output logic r);
		sda_out <= b;
		wt();
		scl_out <= 1'b1;
		wt();
		r = sda_in;
		wt();
		scl_out <= 1'b0;
		wt();
	endtask
	// Eight bits MSB first, then the ninth; ack_in high withholds the ack.
	task automatic byte_io(input logic [7:0] d, input logic ack_in);
		logic [8:0] q;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i+1]);
		bit_io(ack_in, q[0]);
		got_out <= q;
		got_v_out <= 1'b1;
		@(posedge clk_in);
		got_v_out <= 1'b0;
	endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
	logic        sys_clk_in, rstn_in, pf, m_scl, m_sda, s_sda, s_oe, busy, got_v, sda_w;
	logic [5:0]  ptr;
	logic [8:0]  got, e;
	logic [7:0]  mem [64];
	logic [7:0]  d;
	logic [8:0]  exp_q [$];
	int          err_count, n_tests, seed;
	assign sda_w = m_sda & (s_oe ? s_sda : 1'b1);
	rtcsp_slave u_rtcsp_slave (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .scl_in(m_scl),
		.sda_in(sda_w), .sda_out(s_sda), .sda_oe_out(s_oe), .power_fail_in(pf),
		.busy_out(busy), .ptr_out(ptr));
	rtcsp_master_model u_rtcsp_master_model (.clk_in(sys_clk_in), .sda_in(sda_w),
		.scl_out(m_scl), .sda_out(m_sda), .got_v_out(got_v), .got_out(got));
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		if (got_v) begin
			e = exp_q.pop_front();
			`CHK("byte", e, got)
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wb(input logic [7:0] v, input logic a);
		exp_q.push_back({v, a});
		u_rtcsp_master_model.byte_io(v, 1'b1);
	endtask
	task automatic rb(input logic [5:0] ad, input logic a);
		exp_q.push_back({mem[ad], a});
		u_rtcsp_master_model.byte_io(8'hFF, a);
	endtask
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		err_count++;
		print_verdict();
	end
	initial begin
		rstn_in = 1'b0;
		pf = 1'b0;
		seed = 44648;
		err_count = 0;
		n_tests = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (2) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		// Pointer load with upper bits set, then a burst across the top of the map.
		u_rtcsp_master_model.start_c();
		`CHK("busy", 1'b1, busy)
		wb(8'hD0, 1'b0);
		wb(8'hFE, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			mem[6'h3E + 6'(i)] = d;
			wb(d, 1'b0);
		end
		`CHK("ptr", 6'h02, ptr)
		u_rtcsp_master_model.stop_c();
		`CHK("busy", 1'b0, busy)
		$display("test write burst done");
		// A foreign address is never acknowledged.
		u_rtcsp_master_model.start_c();
		wb(8'hD2, 1'b1);
		u_rtcsp_master_model.stop_c();
		`CHK("ptr", 6'h02, ptr)
		$display("test foreign address done");
		// Read back through a repeated start; the final nack must not advance.
		u_rtcsp_master_model.start_c();
		wb(8'hD0, 1'b0);
		wb(8'hFE, 1'b0);
		u_rtcsp_master_model.start_c();
		wb(8'hD1, 1'b0);
		for (int i = 0; i < 4; i++) rb(6'h3E + 6'(i), i == 3);
		u_rtcsp_master_model.stop_c();
		`CHK("ptr", 6'h01, ptr)
		// A bare read starts where the pointer stands.
		u_rtcsp_master_model.start_c();
		wb(8'hD1, 1'b0);
		rb(6'h01, 1'b1);
		u_rtcsp_master_model.stop_c();
		`CHK("ptr", 6'h01, ptr)
		$display("test read done");
		// Supply failure in mid-transfer, then a transfer while it lasts.
		u_rtcsp_master_model.start_c();
		wb(8'hD0, 1'b0);
		wb(8'h05, 1'b0);
		`CHK("ptr", 6'h05, ptr)
		pf <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		`CHK("ptr", 6'h00, ptr)
		`CHK("busy", 1'b0, busy)
		u_rtcsp_master_model.start_c();
		`CHK("busy", 1'b0, busy)
		wb(8'hD0, 1'b1);
		u_rtcsp_master_model.stop_c();
		pf <= 1'b0;
		repeat (10) @(posedge sys_clk_in);
		u_rtcsp_master_model.start_c();
		wb(8'hD1, 1'b0);
		rb(6'h00, 1'b1);
		u_rtcsp_master_model.stop_c();
		`CHK("ptr", 6'h00, ptr)
		$display("test power fail done");
		print_verdict();
	end
endmodule
